// ---- pkg/ric_pkg.sv ----
// Package for the reset and interrupt control block: offsets, fields, vectors, counts and carriers.
// Contract
// - Every reset source loads the 0x1FFE start vector and sets the mask flag.
// - After power-up hold reset a fixed count and drive the reset pin low.
// - Reset pin still low at count end keeps reset until it rises.
// - Low-supply indication resets only while misc_control bit 3 is set.
// - Fixed priority reset, trap, ext, second ext, timer, keyboard, each own vector.
// - Mask flag set holds off maskable requests; clearing it lets them through.
// - Interrupt entry stacks state and sets mask; return restores it.
// - Requests wait for instruction end, then all pending are sampled.
// - Software trap ignores mask; ranks after requests pending at its fetch.
// - External latch clears early in entry so one more pulse can latch.
// - Bit 4 enables external interrupt; register resets to 0x10.
// - Bit 5 set selects falling edge, clear selects low level trigger.
// - Level mode: line still low after service raises a new request.
// - Bit 0 turns port D pin six into second external interrupt.
// - Second external interrupt latches on falling edge; raised only when unmasked.
// - Bit 1 write-only reads 0; writing 1 clears second latch; reset clears.
// - Bit 7 keyboard master enable; bit 6 write-only clears keyboard latch.
// - Timer request needs the timer flag with timer mask and mask flag clear.
package ric_pkg;

  localparam logic [31:0] MISC_CONTROL_ADDR = 32'h0000000C;
  localparam logic [7:0] MISC_CONTROL_RESET = 8'h10;
  localparam int unsigned BIT_SECOND_EN = 0;
  localparam int unsigned BIT_SECOND_CLR = 1;
  localparam int unsigned BIT_SLOW = 2;
  localparam int unsigned BIT_LOW_SUPPLY_EN = 3;
  localparam int unsigned BIT_EXT_EN = 4;
  localparam int unsigned BIT_EXT_EDGE = 5;
  localparam int unsigned BIT_KBD_CLR = 6;
  localparam int unsigned BIT_KBD_EN = 7;
  localparam logic [7:0] MISC_WRITE_ONLY_MASK = 8'h42;

  localparam logic [15:0] VEC_RESET = 16'h1FFE;
  localparam logic [15:0] VEC_TRAP = 16'h1FFC;
  localparam logic [15:0] VEC_EXT = 16'h1FFA;
  localparam logic [15:0] VEC_SECOND = 16'h1FF8;
  localparam logic [15:0] VEC_TIMER = 16'h1FF6;
  localparam logic [15:0] VEC_KBD = 16'h1FF4;

  // Power-up hold count in bus cycles; plain default, the top module passes it on and the bench overrides it.
  localparam int unsigned POWER_UP_HOLD_COUNT = 4064;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    RIC_SRC_NONE = 3'h0,
    RIC_SRC_TRAP = 3'h1,
    RIC_SRC_EXT = 3'h2,
    RIC_SRC_SECOND = 3'h3,
    RIC_SRC_TIMER = 3'h4,
    RIC_SRC_KBD = 3'h5
  } ric_src_t;

  // Request and answer with the processor core.
  typedef struct packed {
    logic insn_done;
    logic trap_fetch;
    logic return_from_interrupt;
    logic mask_flag_write;
    logic mask_flag_value;
  } ric_core_req_t;

  typedef struct packed {
    logic take;
    ric_src_t src;
    logic [15:0] vector;
  } ric_grant_t;

endpackage : ric_pkg

// ---- rtl/ric_reset_merge.sv ----
// Merges power-on, reset pin and low-supply sources into one synchronised reset.
`timescale 1ns/1ps
`default_nettype none
module ric_reset_merge #(
  parameter int unsigned HOLD = ric_pkg::POWER_UP_HOLD_COUNT
) (
  // Clock and power-on reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Sources.
  input wire logic reset_pin_in,
  input wire logic low_supply_reset,
  input wire logic low_supply_reset_enable,
  // Merged reset and pin drive.
  output logic sys_reset_ff,
  output logic reset_pin_drive_ff
);
  typedef struct packed {
    logic [12:0] cnt;
    logic hold_done;
    logic sys_reset;
    logic pin_drive;
  } ric_rm_state_t;

  ric_rm_state_t s_ff;
  ric_rm_state_t nxt_s;

  // Count out the stabilisation time, then follow the pin and supply.
  always_comb begin
    nxt_s = s_ff;
    if (!s_ff.hold_done) begin
      nxt_s.pin_drive = 1'b1;
      if (s_ff.cnt >= 13'(HOLD - 1)) begin
        nxt_s.hold_done = 1'b1;
        nxt_s.pin_drive = 1'b0;
      end else begin
        nxt_s.cnt = s_ff.cnt + 13'h0001;
      end
      nxt_s.sys_reset = 1'b1;
    end else begin
      // Release is registered, so the reset leaves on a clock edge.
      nxt_s.sys_reset = !reset_pin_in || (low_supply_reset && low_supply_reset_enable);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '{cnt: 13'h0000, hold_done: 1'b0, sys_reset: 1'b1, pin_drive: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sys_reset_ff = s_ff.sys_reset;
  assign reset_pin_drive_ff = s_ff.pin_drive;

  a_pin_during_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_ff.hold_done |-> s_ff.pin_drive && s_ff.sys_reset) else $error("pin not driven in hold");
  a_pin_keeps_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ff.hold_done && !reset_pin_in |=> sys_reset_ff) else $error("pin low left reset");
  a_low_supply_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ff.hold_done && reset_pin_in && !low_supply_reset_enable |=> !sys_reset_ff)
    else $error("disabled low supply reset");
endmodule : ric_reset_merge
`default_nettype wire

// ---- rtl/ric_prio.sv ----
// Fixed-priority selector of the pending request and its vector.
`timescale 1ns/1ps
`default_nettype none
module ric_prio (
  // Qualified requests.
  input wire logic trap,
  input wire logic ext,
  input wire logic second,
  input wire logic timer,
  input wire logic kbd,
  // Choice.
  output ric_pkg::ric_src_t src,
  output logic [15:0] vector
);
  // Highest first; reset is handled above this selector.
  always_comb begin
    if (trap) begin
      src = ric_pkg::RIC_SRC_TRAP;
      vector = ric_pkg::VEC_TRAP;
    end else if (ext) begin
      src = ric_pkg::RIC_SRC_EXT;
      vector = ric_pkg::VEC_EXT;
    end else if (second) begin
      src = ric_pkg::RIC_SRC_SECOND;
      vector = ric_pkg::VEC_SECOND;
    end else if (timer) begin
      src = ric_pkg::RIC_SRC_TIMER;
      vector = ric_pkg::VEC_TIMER;
    end else if (kbd) begin
      src = ric_pkg::RIC_SRC_KBD;
      vector = ric_pkg::VEC_KBD;
    end else begin
      src = ric_pkg::RIC_SRC_NONE;
      vector = ric_pkg::VEC_RESET;
    end
  end
endmodule : ric_prio
`default_nettype wire

// ---- rtl/ric_top.sv ----
// Reset and interrupt control top: bus slave, control register, latches and core handshake.
`timescale 1ns/1ps
`default_nettype none
module ric_top #(
  parameter int unsigned POWER_UP_HOLD = ric_pkg::POWER_UP_HOLD_COUNT
) (
  // Bus clock and power-on reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reset pin as three signals and the supply detector.
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic low_supply_reset,
  // Interrupt pins and neighbouring request sources.
  input wire logic ext_int_pin_n,
  input wire logic port_d_pin_six,
  input wire logic timer_overflow_flag,
  input wire logic timer_request_mask,
  input wire logic keyboard_interrupt,
  // Processor core handshake.
  input wire ric_pkg::ric_core_req_t core_req,
  output ric_pkg::ric_grant_t grant,
  output logic core_reset,
  output logic [15:0] start_vector,
  output logic condition_mask_flag,
  output logic keyboard_latch_clear,
  output logic misc_bit_slow,
  output logic keyboard_master_enable
);

  typedef struct packed {
    logic [7:0] misc;
    logic ext_latch;
    logic ext_pin_q;
    logic second_latch;
    logic second_pin_q;
    logic mask_flag;
    logic [1:0] stack_mask;
    logic trap_pending;
    logic trap_early;
    logic dphase_wr;
    logic dphase_rd;
    logic [31:0] rdata;
    ric_pkg::ric_grant_t grant;
    logic kbd_clr;
    logic in_reset;
  } ric_state_t;

  ric_state_t s_ff;
  ric_state_t nxt_s;
  logic sys_reset;
  logic pin_drive;
  ric_pkg::ric_src_t sel_src;
  logic [15:0] sel_vec;
  logic ext_req;
  logic second_req;
  logic timer_req;
  logic kbd_req;
  logic trap_first;
  logic any_hw;

  // Address phase is valid on a selected non-sequential transfer to the control word.
  function automatic logic hit(input logic [31:0] a);
    return a[31:2] == ric_pkg::MISC_CONTROL_ADDR[31:2];
  endfunction : hit

  ric_reset_merge #(.HOLD(POWER_UP_HOLD)) u_reset (
    .hclk(hclk),
    .hresetn(hresetn),
    .reset_pin_in(reset_pin_in),
    .low_supply_reset(low_supply_reset),
    .low_supply_reset_enable(s_ff.misc[ric_pkg::BIT_LOW_SUPPLY_EN]),
    .sys_reset_ff(sys_reset),
    .reset_pin_drive_ff(pin_drive)
  );

  // Requests qualified by the mask flag; timer and keyboard also by their own mask or enable.
  always_comb begin
    ext_req = s_ff.ext_latch && !s_ff.mask_flag;
    second_req = s_ff.second_latch && !s_ff.mask_flag;
    timer_req = timer_overflow_flag && !timer_request_mask && !s_ff.mask_flag;
    kbd_req = keyboard_interrupt && s_ff.misc[ric_pkg::BIT_KBD_EN] && !s_ff.mask_flag;
    any_hw = ext_req || second_req || timer_req || kbd_req;
    // A trap yields to hardware requests that were already pending at its fetch.
    trap_first = s_ff.trap_pending && !(s_ff.trap_early && any_hw);
  end

  ric_prio u_prio (
    .trap(trap_first),
    .ext(ext_req),
    .second(second_req),
    .timer(timer_req),
    .kbd(kbd_req),
    .src(sel_src),
    .vector(sel_vec)
  );

  // One next-state process for the whole block.
  always_comb begin
    logic wr_now;
    logic ext_low;
    logic ext_fall;
    logic sec_fall;
    logic [7:0] wval;
    wr_now = s_ff.dphase_wr;
    wval = hwdata[7:0];
    nxt_s = s_ff;
    nxt_s.grant.take = 1'b0;
    nxt_s.kbd_clr = 1'b0;
    nxt_s.in_reset = 1'b0;
    nxt_s.ext_pin_q = ext_int_pin_n;
    nxt_s.second_pin_q = port_d_pin_six;
    ext_low = !ext_int_pin_n;
    ext_fall = s_ff.ext_pin_q && !ext_int_pin_n;
    sec_fall = s_ff.second_pin_q && !port_d_pin_six;

    // Bus data phase: one wait-free cycle, response always OKAY.
    nxt_s.dphase_wr = hsel && hready && htrans == ric_pkg::HTRANS_NONSEQ && hwrite && hit(haddr);
    nxt_s.dphase_rd = hsel && hready && htrans == ric_pkg::HTRANS_NONSEQ && !hwrite;
    if (hsel && hready && htrans == ric_pkg::HTRANS_NONSEQ && !hwrite) begin
      // Write-only clear bits always read back as zero; other addresses read zero.
      nxt_s.rdata = hit(haddr) ? {24'h000000, s_ff.misc & ~ric_pkg::MISC_WRITE_ONLY_MASK} : 32'h00000000;
    end
    if (wr_now) begin
      nxt_s.misc = wval & ~ric_pkg::MISC_WRITE_ONLY_MASK;
      if (wval[ric_pkg::BIT_SECOND_CLR]) begin
        nxt_s.second_latch = 1'b0;
      end
      nxt_s.kbd_clr = wval[ric_pkg::BIT_KBD_CLR];
    end

    // External pin: edge sets a latch, level mode follows the line while it stays low.
    if (s_ff.misc[ric_pkg::BIT_EXT_EN]) begin
      if (s_ff.misc[ric_pkg::BIT_EXT_EDGE]) begin
        if (ext_fall) begin
          nxt_s.ext_latch = 1'b1;
        end
      end else if (ext_low) begin
        nxt_s.ext_latch = 1'b1;
      end
    end else begin
      nxt_s.ext_latch = 1'b0;
    end

    // Second pin latches falling edges only while its enable is set.
    if (s_ff.misc[ric_pkg::BIT_SECOND_EN] && sec_fall) begin
      nxt_s.second_latch = 1'b1;
    end

    // Core events: trap fetch, mask flag write, return and instruction end.
    if (core_req.trap_fetch) begin
      nxt_s.trap_pending = 1'b1;
      nxt_s.trap_early = any_hw;
    end
    if (core_req.mask_flag_write) begin
      nxt_s.mask_flag = core_req.mask_flag_value;
    end
    if (core_req.return_from_interrupt) begin
      nxt_s.mask_flag = s_ff.stack_mask[0];
      nxt_s.stack_mask = {1'b0, s_ff.stack_mask[1]};
    end
    if (core_req.insn_done && sel_src != ric_pkg::RIC_SRC_NONE) begin
      // Sampling happens only here, so a running instruction is never cut short.
      nxt_s.grant.take = 1'b1;
      nxt_s.grant.src = sel_src;
      nxt_s.grant.vector = sel_vec;
      nxt_s.mask_flag = 1'b1;
      nxt_s.stack_mask = {s_ff.stack_mask[0], s_ff.mask_flag};
      if (sel_src == ric_pkg::RIC_SRC_TRAP) begin
        nxt_s.trap_pending = 1'b0;
        nxt_s.trap_early = 1'b0;
      end
      if (sel_src == ric_pkg::RIC_SRC_EXT) begin
        // Cleared at entry; an edge in this cycle still wins, so one pulse is not lost.
        nxt_s.ext_latch = s_ff.misc[ric_pkg::BIT_EXT_EDGE] ? ext_fall : ext_low;
      end
    end

    // A merged reset restores the control word, latches, mask, stack and trap state, and points the core at the start vector.
    if (sys_reset) begin
      nxt_s.misc = ric_pkg::MISC_CONTROL_RESET;
      nxt_s.ext_latch = 1'b0;
      nxt_s.second_latch = 1'b0;
      nxt_s.mask_flag = 1'b1;
      nxt_s.stack_mask = 2'h0;
      nxt_s.trap_pending = 1'b0;
      nxt_s.trap_early = 1'b0;
      nxt_s.grant = '{take: 1'b0, src: ric_pkg::RIC_SRC_NONE, vector: ric_pkg::VEC_RESET};
      nxt_s.in_reset = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '{misc: ric_pkg::MISC_CONTROL_RESET, ext_latch: 1'b0, ext_pin_q: 1'b1,
                second_latch: 1'b0, second_pin_q: 1'b1, mask_flag: 1'b1, stack_mask: 2'h0,
                trap_pending: 1'b0, trap_early: 1'b0, dphase_wr: 1'b0, dphase_rd: 1'b0,
                rdata: 32'h00000000,
                grant: '{take: 1'b0, src: ric_pkg::RIC_SRC_NONE, vector: ric_pkg::VEC_RESET},
                kbd_clr: 1'b0, in_reset: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs come straight from state flip-flops or are tied to constants.
  assign hrdata = s_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = pin_drive;
  assign grant = s_ff.grant;
  assign core_reset = s_ff.in_reset;
  assign start_vector = ric_pkg::VEC_RESET;
  assign condition_mask_flag = s_ff.mask_flag;
  assign keyboard_latch_clear = s_ff.kbd_clr;
  assign misc_bit_slow = s_ff.misc[ric_pkg::BIT_SLOW];
  assign keyboard_master_enable = s_ff.misc[ric_pkg::BIT_KBD_EN];

  sequence s_taken;
    grant.take;
  endsequence

  a_reset_sets_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    sys_reset |=> condition_mask_flag && core_reset && grant.vector == 16'h1FFE) else $error("reset no mask");
  a_mask_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    condition_mask_flag && !s_ff.trap_pending |=> !grant.take) else $error("masked taken");
  a_entry_masks: assert property (@(posedge hclk) disable iff (!hresetn)
    s_taken and !$past(sys_reset) |-> condition_mask_flag) else $error("entry left mask clear");
  a_only_at_end: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(core_req.insn_done) |-> !grant.take) else $error("taken mid instruction");
  a_ext_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    grant.take && grant.src == ric_pkg::RIC_SRC_EXT |-> grant.vector == 16'h1FFA) else $error("bad ext vector");
  a_second_wr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ff.dphase_wr && hwdata[1] && !sys_reset && !(port_d_pin_six == 1'b0 && s_ff.second_pin_q)
    |=> !s_ff.second_latch) else $error("second latch not cleared");
  a_read_zero_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(s_ff.dphase_rd) || s_ff.dphase_rd |-> hrdata[1] == 1'b0 && hrdata[6] == 1'b0)
    else $error("write-only bit read as one");
  a_level_retrig: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ff.misc[4] && !s_ff.misc[5] && !ext_int_pin_n && !sys_reset |=> s_ff.ext_latch)
    else $error("level low not latched");
  a_timer_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    grant.take && grant.src == ric_pkg::RIC_SRC_TIMER |-> !$past(timer_request_mask))
    else $error("masked timer taken");
  a_trap_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    grant.take && grant.src == ric_pkg::RIC_SRC_TRAP |-> grant.vector == 16'h1FFC) else $error("bad trap vector");
endmodule : ric_top
`default_nettype wire

// ---- test/ric_core_model.sv ----
// Processor core model that turns bench commands into one-cycle core requests.
`timescale 1ns/1ps
`default_nettype none
module ric_core_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Commands from the bench.
  input wire logic cmd_go,
  input wire ric_pkg::ric_core_req_t cmd,
  // Design side.
  input wire logic core_reset,
  output ric_pkg::ric_core_req_t core_req
);
  // A held command would look like a second instruction end, so every request lasts one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_req <= '0;
    end else begin
      core_req <= (cmd_go && !core_reset) ? cmd : '0;
    end
  end
endmodule : ric_core_model
`default_nettype wire

// ---- test/reset_and_interrupt_control_bench.sv ----
// Self-checking bench for the reset and interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_control_bench;
  localparam int unsigned HOLD = 8;
  localparam logic [31:0] MC = ric_pkg::MISC_CONTROL_ADDR;
  localparam logic [4:0] STEP = 5'h10;
  localparam logic [4:0] CLI = 5'h02;
  localparam logic [4:0] TRAP = 5'h08;
  localparam logic [4:0] RETURN_FROM_INTERRUPT = 5'h04;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  wire logic reset_pin_in;
  logic reset_pin_out;
  logic reset_pin_oe;
  logic pin_ext_low = 1'b0;
  logic low_supply_reset = 1'b0;
  logic ext_int_pin_n = 1'b1;
  logic port_d_pin_six = 1'b1;
  logic timer_overflow_flag = 1'b0;
  logic timer_request_mask = 1'b1;
  logic keyboard_interrupt = 1'b0;
  logic cmd_go = 1'b0;
  ric_pkg::ric_core_req_t cmd = '0;
  ric_pkg::ric_core_req_t core_req;
  ric_pkg::ric_grant_t grant;
  logic core_reset;
  logic [15:0] start_vector;
  logic condition_mask_flag;
  logic keyboard_latch_clear;
  logic misc_bit_slow;
  logic keyboard_master_enable;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] d;
  logic [31:0] r;

  // The one slave's ready is the bus ready; the reset pin has a pull-up and is pulled by either party.
  assign hready = hreadyout;
  assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || pin_ext_low) ? 1'b0 : 1'b1;

  ric_top #(.POWER_UP_HOLD(HOLD)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .low_supply_reset,
    .ext_int_pin_n, .port_d_pin_six, .timer_overflow_flag, .timer_request_mask, .keyboard_interrupt,
    .core_req, .grant, .core_reset, .start_vector, .condition_mask_flag, .keyboard_latch_clear,
    .misc_bit_slow, .keyboard_master_enable);

  ric_core_model core_model (.hclk, .hresetn, .cmd_go, .cmd, .core_reset, .core_req);

  // Clock of 20 ns period.
  always #10 hclk = ~hclk;

  // A hang ends the run as a failure.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  function automatic logic [15:0] vec_of(input logic [2:0] s);
    case (s)
      3'h1: return ric_pkg::VEC_TRAP;
      3'h2: return ric_pkg::VEC_EXT;
      3'h3: return ric_pkg::VEC_SECOND;
      3'h4: return ric_pkg::VEC_TIMER;
      default: return ric_pkg::VEC_KBD;
    endcase
  endfunction : vec_of

  task automatic chk_grant(input logic take, input logic [2:0] s);
    total_checks++;
    if (grant.take !== take || (take && ({grant.src} !== s || grant.vector !== vec_of(s) ||
        condition_mask_flag !== 1'b1))) begin
      num_errors++;
      $display("Error grant expected %b %h %h seen %b %h %h", take, s, vec_of(s), grant.take, grant.src,
        grant.vector);
    end
  endtask : chk_grant

  // Address phase held until ready, then data phase held until ready; read data taken at that edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= ric_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk_val("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr

  // The core answers after a random stall of zero to two cycles.
  task automatic core(input logic [4:0] c);
    repeat ($urandom_range(2)) @(posedge hclk);
    cmd <= ric_pkg::ric_core_req_t'(c);
    cmd_go <= 1'b1;
    @(posedge hclk);
    cmd_go <= 1'b0;
    @(posedge hclk);
    #1;
  endtask : core

  task automatic step(input logic take, input logic [2:0] s);
    core(STEP);
    chk_grant(take, s);
  endtask : step

  task automatic wait_rel(input int lim);
    n = 0;
    while (core_reset !== 1'b0 && n < lim) begin
      @(posedge hclk);
      #1;
      n++;
    end
  endtask : wait_rel

  task automatic pulse_ext();
    @(posedge hclk);
    ext_int_pin_n <= 1'b0;
    @(posedge hclk);
    ext_int_pin_n <= 1'b1;
  endtask : pulse_ext

  // Main sequence.
  initial begin
    d = $urandom(2249);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk_val("pin_oe", 32'h1, {31'h0, reset_pin_oe});
    chk_val("pin_out", 32'h0, {31'h0, reset_pin_out});
    chk_val("start_vector", 32'h1FFE, {16'h0, start_vector});
    chk_val("mask", 32'h1, {31'h0, condition_mask_flag});
    wait_rel(40);
    chk_val("hold_len", 32'h1, {31'h0, n >= HOLD - 1 && n <= HOLD + 3});
    chk_val("pin_oe_off", 32'h0, {31'h0, reset_pin_oe});
    bus(1'b0, MC, 32'h0, r);
    chk_val("misc_reset", 32'h10, r);
    wr(32'h8, 32'hFF);
    bus(1'b0, 32'h8, 32'h0, r);
    chk_val("unmapped", 32'h0, r);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hF7 : (i == 1) ? 32'h0 : ($urandom & 32'hF7);
      wr(MC, d);
      // The clear pulse stands for the one cycle after the data phase.
      #1;
      chk_val("kbd_clear", {31'h0, d[6]}, {31'h0, keyboard_latch_clear});
      bus(1'b0, MC, 32'h0, r);
      chk_val("misc", d & 32'hBD, r);
      chk_val("slow_kbd_en", {30'h0, d[7], d[2]}, {30'h0, keyboard_master_enable, misc_bit_slow});
    end
    // Level trigger: masked, then taken, then taken again while the line stays low.
    wr(MC, 32'h10);
    ext_int_pin_n <= 1'b0;
    core(TRAP);
    chk_grant(1'b0, 3'h0);
    step(1'b1, 3'h1);
    step(1'b0, 3'h0);
    core(CLI);
    step(1'b1, 3'h2);
    core(CLI);
    step(1'b1, 3'h2);
    wr(MC, 32'h81);
    ext_int_pin_n <= 1'b1;
    // Priority among second pin, timer and keyboard.
    port_d_pin_six <= 1'b0;
    timer_overflow_flag <= 1'b1;
    timer_request_mask <= 1'b0;
    keyboard_interrupt <= 1'b1;
    core(CLI);
    step(1'b1, 3'h3);
    wr(MC, 32'h83);
    core(CLI);
    step(1'b1, 3'h4);
    timer_overflow_flag <= 1'b0;
    core(CLI);
    step(1'b1, 3'h5);
    keyboard_interrupt <= 1'b0;
    port_d_pin_six <= 1'b1;
    core(TRAP);
    chk_grant(1'b0, 3'h0);
    step(1'b1, 3'h1);
    core(RETURN_FROM_INTERRUPT);
    chk_val("rti_mask", 32'h1, {31'h0, condition_mask_flag});
    core(RETURN_FROM_INTERRUPT);
    chk_val("rti_mask", 32'h0, {31'h0, condition_mask_flag});
    // Edge trigger: one pulse latches once, and a pulse during service waits for the mask.
    wr(MC, 32'h30);
    pulse_ext();
    step(1'b1, 3'h2);
    pulse_ext();
    step(1'b0, 3'h0);
    core(CLI);
    step(1'b1, 3'h2);
    core(CLI);
    step(1'b0, 3'h0);
    // A trap fetched while a request is pending yields to it, then follows it.
    pulse_ext();
    core(TRAP);
    step(1'b1, 3'h2);
    step(1'b1, 3'h1);
    core(CLI);
    // Second pin disabled, then a latched edge cleared by software.
    wr(MC, 32'h00);
    port_d_pin_six <= 1'b0;
    step(1'b0, 3'h0);
    port_d_pin_six <= 1'b1;
    wr(MC, 32'h01);
    port_d_pin_six <= 1'b0;
    wr(MC, 32'h03);
    step(1'b0, 3'h0);
    // Low-supply indication ignored until enabled.
    low_supply_reset <= 1'b1;
    repeat (5) @(posedge hclk);
    #1;
    chk_val("lsr_off", 32'h0, {31'h0, core_reset});
    wr(MC, 32'h18);
    n = 0;
    repeat (6) begin
      @(posedge hclk);
      #1;
      n = n | core_reset;
    end
    chk_val("lsr_on", 32'h1, n);
    low_supply_reset <= 1'b0;
    wait_rel(40);
    bus(1'b0, MC, 32'h0, r);
    chk_val("misc_after", 32'h10, r);
    chk_val("mask_after", 32'h1, {31'h0, condition_mask_flag});
    // Power-up with the reset pin held low past the hold count.
    @(posedge hclk);
    hresetn <= 1'b0;
    pin_ext_low <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (HOLD + 6) @(posedge hclk);
    #1;
    chk_val("pin_hold", 32'h1, {31'h0, core_reset});
    pin_ext_low <= 1'b0;
    wait_rel(6);
    chk_val("pin_free", 32'h1, {31'h0, n < 6});
    results();
  end
endmodule : reset_and_interrupt_control_bench
`default_nettype wire
